// file: inc/ppcr_pkg.sv
// ****************************************************************
// Constants of the first-stage charge pump control registers
// ****************************************************************
package ppcr_pkg;

  // Register byte type
  typedef logic [7:0] ppcr_byte_t;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam ppcr_byte_t ADDR_GAIN_CTRL = 8'h1C;
  localparam ppcr_byte_t ADDR_OFFSET_CTRL = 8'h1D;

  // ****************************************************************
  // Field positions of the gain control register
  // ****************************************************************
  localparam int GAIN_PD_BIT = 7;
  localparam int GAIN_RSVD_BIT = 6;
  localparam int GAIN_SINK_BIT = 5;
  localparam int GAIN_X2_BIT = 4;
  localparam int GAIN_CODE_LSB = 0;
  localparam int GAIN_CODE_W = 4;

  // ****************************************************************
  // Field positions of the offset control register
  // ****************************************************************
  localparam int OFS_POL_BIT = 7;
  localparam int OFS_FCV_BIT = 6;
  localparam int OFS_CODE_LSB = 0;
  localparam int OFS_CODE_W = 6;

  // ****************************************************************
  // Reset values, gain write mask and idle read data
  // ****************************************************************
  localparam ppcr_byte_t GAIN_CTRL_RESET = 8'h30;
  localparam ppcr_byte_t OFFSET_CTRL_RESET = 8'h40;
  localparam ppcr_byte_t GAIN_CTRL_WMASK = 8'hBF;
  localparam ppcr_byte_t RDATA_IDLE = 8'h00;

  // ****************************************************************
  // Current scaling, gain in 100uA units, offset in 12.5uA units
  // ****************************************************************
  localparam int GAIN_CUR_W = 5;
  localparam int OFS_CUR_W = 6;
  localparam int TOTAL_CUR_W = 9;
  localparam logic [4:0] GAIN_X2_BASE = 5'h10;
  localparam logic [4:0] GAIN_MAX = 5'h1E;
  localparam logic [5:0] OFS_MAX = 6'h27;
  localparam logic [5:0] OFS_W5 = 6'h10;
  localparam logic [5:0] OFS_W4 = 6'h08;
  localparam logic [5:0] OFS_W3 = 6'h08;
  localparam logic [5:0] OFS_W2 = 6'h04;
  localparam logic [5:0] OFS_W1 = 6'h02;
  localparam logic [5:0] OFS_W0 = 6'h01;

endpackage

// file: rtl/ppcr_current_calc.sv
`timescale 1ns/10ps
// ****************************************************************
// Commanded pump current from gain, step and offset fields
// ****************************************************************
module ppcr_current_calc (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Stored fields
  input wire logic i_power_down,
  input wire logic i_step_double,
  input wire logic [3:0] i_gain_code,
  input wire logic [5:0] i_offset_code,
  // Commanded currents
  output logic [4:0] o_gain_100ua,
  output logic [5:0] o_offset_12p5ua,
  output logic [8:0] o_total_12p5ua
);

  logic [4:0] gain_d;
  logic [4:0] gain_q;
  logic [5:0] ofs_d;
  logic [5:0] ofs_q;
  logic [8:0] total_d;
  logic [8:0] total_q;
  wire logic [4:0] gain_x1;
  wire logic [4:0] gain_x2;

  // Offset weighting of the six code bits
  function automatic logic [5:0] ofs_weight(input logic [5:0] c);
    ofs_weight = (c[5] ? ppcr_pkg::OFS_W5 : 6'h00) + (c[4] ? ppcr_pkg::OFS_W4 : 6'h00)
      + (c[3] ? ppcr_pkg::OFS_W3 : 6'h00) + (c[2] ? ppcr_pkg::OFS_W2 : 6'h00)
      + (c[1] ? ppcr_pkg::OFS_W1 : 6'h00) + (c[0] ? ppcr_pkg::OFS_W0 : 6'h00);
  endfunction

  // Gain in either step size, power down zeroes all currents
  assign gain_x1 = {1'b0, i_gain_code};
  assign gain_x2 = ppcr_pkg::GAIN_X2_BASE + {1'b0, i_gain_code[2:0], 1'b0};
  assign gain_d = i_power_down ? 5'h00 : (i_step_double ? gain_x2 : gain_x1);
  assign ofs_d = i_power_down ? 6'h00 : ofs_weight(i_offset_code);
  assign total_d = {1'b0, gain_d, 3'b000} + {3'b000, ofs_d};

  // Registered current outputs
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gain_q <= 5'h00;
      ofs_q <= 6'h00;
      total_q <= 9'h000;
    end else begin
      gain_q <= gain_d;
      ofs_q <= ofs_d;
      total_q <= total_d;
    end
  end

  assign o_gain_100ua = gain_q;
  assign o_offset_12p5ua = ofs_q;
  assign o_total_12p5ua = total_q;

  // Unit steps with the multiplier clear
  AST_GAIN_X1: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!i_power_down && !i_step_double) |=> (o_gain_100ua == {1'b0, $past(i_gain_code)}))
    else $error("gain mismatch in 100uA steps");

  // Base plus double steps with the multiplier set
  AST_GAIN_X2: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!i_power_down && i_step_double) |=>
    (o_gain_100ua == ppcr_pkg::GAIN_X2_BASE + {1'b0, $past(i_gain_code[2:0]), 1'b0}))
    else $error("gain mismatch in 200uA steps");

  // Commanded gain never passes 3mA
  AST_GAIN_MAX: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_gain_100ua <= ppcr_pkg::GAIN_MAX)
    else $error("gain current above 3mA");

  // Offset weighted sum and its range
  AST_OFS_SUM: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !i_power_down |=> (o_offset_12p5ua == ofs_weight($past(i_offset_code)))
    && (o_offset_12p5ua <= ppcr_pkg::OFS_MAX))
    else $error("offset current mismatch");

  // Offset adds onto the pump output
  AST_TOTAL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_total_12p5ua == {1'b0, o_gain_100ua, 3'b000} + {3'b000, o_offset_12p5ua})
    else $error("total current is not gain plus offset");

endmodule

// file: rtl/ppcr_top.sv
`timescale 1ns/10ps
// ****************************************************************
// First-stage loop charge pump control register bank
// ****************************************************************

module ppcr_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Register access port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Pump controls
  output logic o_pump_power_down,
  output logic o_pump_sink_enable,
  output logic o_pump_step_double,
  output logic [3:0] o_pump_gain_code,
  output logic o_control_voltage_polarity,
  output logic o_force_mid_control_voltage,
  output logic [5:0] o_pump_offset_code,
  // Commanded currents
  output logic [4:0] o_pump_gain_100ua,
  output logic [5:0] o_pump_offset_12p5ua,
  output logic [8:0] o_pump_total_12p5ua
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] gain_ctrl_q;
  logic [7:0] gain_ctrl_d;
  logic [7:0] ofs_ctrl_q;
  logic [7:0] ofs_ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  wire logic hit_gain;
  wire logic hit_ofs;
  wire logic wr_gain;
  wire logic wr_ofs;
  wire logic [7:0] rd_mux;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Decode of the two mapped offsets
  assign hit_gain = (i_reg_addr == ppcr_pkg::ADDR_GAIN_CTRL);
  assign hit_ofs = (i_reg_addr == ppcr_pkg::ADDR_OFFSET_CTRL);
  assign wr_gain = i_reg_write && hit_gain;
  assign wr_ofs = i_reg_write && hit_ofs;

  // ****************************************************************
  // Register storage
  // ****************************************************************

  // Next value, reserved bit is masked so it never stores
  assign gain_ctrl_d = wr_gain ? (i_reg_wdata & ppcr_pkg::GAIN_CTRL_WMASK) : gain_ctrl_q;
  assign ofs_ctrl_d = wr_ofs ? i_reg_wdata : ofs_ctrl_q;

  // Gain control register, power up, sink on, double steps, code zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gain_ctrl_q <= ppcr_pkg::GAIN_CTRL_RESET;
    end else begin
      gain_ctrl_q <= gain_ctrl_d;
    end
  end

  // Offset control register, positive polarity, forced mid, code zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ofs_ctrl_q <= ppcr_pkg::OFFSET_CTRL_RESET;
    end else begin
      ofs_ctrl_q <= ofs_ctrl_d;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************

  // Read select, unmapped offsets answer zero
  assign rd_mux = hit_gain ? gain_ctrl_q : (hit_ofs ? ofs_ctrl_q : ppcr_pkg::RDATA_IDLE);
  assign rdata_d = i_reg_read ? rd_mux : rdata_q;

  // Read data held until the next read
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= ppcr_pkg::RDATA_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= i_reg_read;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // ****************************************************************
  // Field outputs to the analog pump
  // ****************************************************************

  // Gain register fields
  assign o_pump_power_down = gain_ctrl_q[ppcr_pkg::GAIN_PD_BIT];
  assign o_pump_sink_enable = gain_ctrl_q[ppcr_pkg::GAIN_SINK_BIT];
  assign o_pump_step_double = gain_ctrl_q[ppcr_pkg::GAIN_X2_BIT];
  assign o_pump_gain_code = gain_ctrl_q[ppcr_pkg::GAIN_CODE_LSB +: ppcr_pkg::GAIN_CODE_W];

  // Offset register fields, force stays until the host clears it
  assign o_control_voltage_polarity = ofs_ctrl_q[ppcr_pkg::OFS_POL_BIT];
  assign o_force_mid_control_voltage = ofs_ctrl_q[ppcr_pkg::OFS_FCV_BIT];
  assign o_pump_offset_code = ofs_ctrl_q[ppcr_pkg::OFS_CODE_LSB +: ppcr_pkg::OFS_CODE_W];

  // ****************************************************************
  // Current computation
  // ****************************************************************

  // Registered commanded currents
  ppcr_current_calc u_calc (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_power_down(o_pump_power_down),
    .i_step_double(o_pump_step_double),
    .i_gain_code(o_pump_gain_code),
    .i_offset_code(o_pump_offset_code),
    .o_gain_100ua(o_pump_gain_100ua),
    .o_offset_12p5ua(o_pump_offset_12p5ua),
    .o_total_12p5ua(o_pump_total_12p5ua)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Power-down bit follows a write to the gain register
  AST_PD_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_gain |=> (o_pump_power_down == $past(i_reg_wdata[7])))
    else $error("power down bit did not follow write");

  // Powered down pump commands no current one cycle later
  AST_PD_ZERO: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_pump_power_down |=> (o_pump_total_12p5ua == 9'h000))
    else $error("current commanded while powered down");

  // Sink enable follows a write
  AST_SINK_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_gain |=> (o_pump_sink_enable == $past(i_reg_wdata[5])))
    else $error("sink enable did not follow write");

  // Step select follows a write
  AST_STEP_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_gain |=> (o_pump_step_double == $past(i_reg_wdata[4])))
    else $error("step select did not follow write");

  // Polarity follows a write and is otherwise steady
  AST_POL_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_ofs |=> (o_control_voltage_polarity == $past(i_reg_wdata[7])))
    else $error("polarity did not follow write");

  // Force bit follows a write
  AST_FORCE_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_ofs |=> (o_force_mid_control_voltage == $past(i_reg_wdata[6])))
    else $error("force bit did not follow write");

  // Force bit only drops through a host write
  AST_FORCE_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!wr_ofs && o_force_mid_control_voltage) |=> o_force_mid_control_voltage)
    else $error("force bit dropped without a write");

  // Offset code follows a write
  AST_OFS_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_ofs |=> (o_pump_offset_code == $past(i_reg_wdata[5:0])))
    else $error("offset code did not follow write");

  // Reserved bit reads as zero after any write
  AST_RSVD_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_reg_read && hit_gain) |=> (o_reg_rvalid && !o_reg_rdata[6]))
    else $error("reserved bit read back nonzero");

  // Gain code read back matches the stored field
  AST_GAIN_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_reg_read && hit_gain && !i_reg_write) |=> (o_reg_rdata[3:0] == o_pump_gain_code))
    else $error("gain code read back mismatch");

  // ****************************************************************
  // Storage checks
  // ****************************************************************

  // Gain code follows a write
  AST_GAIN_CODE_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_gain |=> (o_pump_gain_code == $past(i_reg_wdata[3:0])))
    else $error("gain code did not follow write");

  // Reserved bit never holds a one
  AST_RSVD_STORE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    gain_ctrl_q[ppcr_pkg::GAIN_RSVD_BIT] == 1'b0)
    else $error("reserved bit stored a one");

  // A one written to the reserved bit is dropped
  AST_RSVD_WRITE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_gain && i_reg_wdata[6]) |=> !gain_ctrl_q[ppcr_pkg::GAIN_RSVD_BIT])
    else $error("reserved bit took a write");

  // Gain register keeps its value without a write to it
  AST_GAIN_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_gain |=> $stable(gain_ctrl_q))
    else $error("gain register changed without a write");

  // Offset register keeps its value without a write to it
  AST_OFS_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_ofs |=> $stable(ofs_ctrl_q))
    else $error("offset register changed without a write");

  // Sink enable steady between writes
  AST_SINK_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_gain |=> $stable(o_pump_sink_enable))
    else $error("sink enable changed without a write");

  // Step select steady between writes
  AST_STEP_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_gain |=> $stable(o_pump_step_double))
    else $error("step select changed without a write");

  // Gain code steady between writes
  AST_GAIN_CODE_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_gain |=> $stable(o_pump_gain_code))
    else $error("gain code changed without a write");

  // Polarity steady between writes
  AST_POL_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_ofs |=> $stable(o_control_voltage_polarity))
    else $error("polarity changed without a write");

  // Offset code steady between writes
  AST_OFS_CODE_HOLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !wr_ofs |=> $stable(o_pump_offset_code))
    else $error("offset code changed without a write");

  // Force bit never rises without a write
  AST_FORCE_SET: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!wr_ofs && !o_force_mid_control_voltage) |=> !o_force_mid_control_voltage)
    else $error("force bit rose without a write");

  // A write with the force bit clear releases the loop
  AST_FORCE_CLEAR: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_ofs && !i_reg_wdata[6]) |=> !o_force_mid_control_voltage)
    else $error("force bit stayed after a clearing write");

  // ****************************************************************
  // Read port checks
  // ****************************************************************

  // Whole gain register reads back with bit 6 clear
  AST_GAIN_READ_ALL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_reg_read && hit_gain && !i_reg_write) |=> (o_reg_rdata == {o_pump_power_down, 1'b0,
    o_pump_sink_enable, o_pump_step_double, o_pump_gain_code}))
    else $error("gain register read back mismatch");

  // Read in the same cycle as a write returns the old value
  AST_READ_OLD: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_reg_read && hit_gain) |=> (o_reg_rdata == $past(gain_ctrl_q)))
    else $error("gain read did not return the stored value");

  // Offset register reads back all three fields
  AST_OFS_READ: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_reg_read && hit_ofs && !i_reg_write) |=> (o_reg_rdata == {o_control_voltage_polarity,
    o_force_mid_control_voltage, o_pump_offset_code}))
    else $error("offset register read back mismatch");

  // ****************************************************************
  // Current checks
  // ****************************************************************

  // Powered-down pump commands no gain current
  AST_PD_NO_GAIN: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_pump_power_down |=> (o_pump_gain_100ua == 5'h00))
    else $error("gain current while powered down");

  // Powered-down pump commands no offset current
  AST_PD_NO_OFS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_pump_power_down |=> (o_pump_offset_12p5ua == 6'h00))
    else $error("offset current while powered down");

  // Double steps never fall below the 1.6mA base
  AST_STEP_BASE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!o_pump_power_down && o_pump_step_double) |=> (o_pump_gain_100ua >= ppcr_pkg::GAIN_X2_BASE))
    else $error("double step gain below base");

  // Unit steps never pass 1.5mA
  AST_STEP_UNIT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!o_pump_power_down && !o_pump_step_double) |=> (o_pump_gain_100ua <= 5'h0F))
    else $error("unit step gain above 1.5mA");

  // Total current stays within gain and offset maxima
  AST_TOTAL_MAX: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_pump_total_12p5ua <= 9'h117)
    else $error("total current above its maximum");

endmodule

// file: testbench/ppcr_top_tb_top.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench of the charge pump control register bank
// ****************************************************************
module ppcr_top_tb_top;
  logic clock;
  logic arst_n;
  logic [7:0] reg_addr;
  logic reg_write;
  logic [7:0] reg_wdata;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic pd;
  logic sink;
  logic step;
  logic [3:0] gcode;
  logic pol;
  logic force_mid;
  logic [5:0] ocode;
  logic [4:0] gain_cur;
  logic [5:0] ofs_cur;
  logic [8:0] tot_cur;
  int fails;
  int checked;

  ppcr_top i_ppcr_top (
    .i_clock(clock), .i_arst_n(arst_n), .i_reg_addr(reg_addr), .i_reg_write(reg_write),
    .i_reg_wdata(reg_wdata), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid), .o_pump_power_down(pd), .o_pump_sink_enable(sink),
    .o_pump_step_double(step), .o_pump_gain_code(gcode),
    .o_control_voltage_polarity(pol), .o_force_mid_control_voltage(force_mid),
    .o_pump_offset_code(ocode), .o_pump_gain_100ua(gain_cur),
    .o_pump_offset_12p5ua(ofs_cur), .o_pump_total_12p5ua(tot_cur)
  );

  // ****************************************************************
  // Clock generation
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare one value and count it
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register write, returns once the currents have followed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  // Register read with expected data and one-cycle valid pulse
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
    @(negedge clock);
    chk(reg_rvalid, 1'b0);
  endtask

  // Reset values of both registers and the derived currents
  task automatic test_reset();
    rd(8'h1C, 8'h30);
    rd(8'h1D, 8'h40);
    chk(gain_cur, 9'h010);
    chk(ofs_cur, 9'h000);
    chk(tot_cur, 9'h080);
    chk({pd, sink, step, force_mid, pol}, 9'h00E);
    $display("test reset done");
  endtask

  // Every gain code in both step modes, offset still zero
  task automatic test_gain();
    logic [8:0] e;
    for (int x = 0; x < 2; x++) begin
      for (int c = 0; c < 16; c++) begin
        wr(8'h1C, {3'b001, x[0], c[3:0]});
        e = x[0] ? 9'(16 + 2 * c[2:0]) : 9'(c[3:0]);
        chk(gain_cur, e);
        chk(tot_cur, 9'(e * 8));
        chk({step, gcode}, {x[0], c[3:0]});
      end
    end
    wr(8'h1C, 8'h0F);
    chk(sink, 1'b0);
    $display("test gain done");
  endtask

  // Offset weights, polarity and force bit, host clears force
  task automatic test_offset();
    int w [6] = '{1, 2, 4, 8, 8, 16};
    for (int i = 0; i < 6; i++) begin
      wr(8'h1D, 8'(1 << i));
      chk(ofs_cur, 9'(w[i]));
      chk(tot_cur, 9'(120 + w[i]));
      chk({pol, force_mid, ocode}, 9'(1 << i));
    end
    wr(8'h1D, 8'hBF);
    chk(ofs_cur, 9'h027);
    chk(tot_cur, 9'h09F);
    chk({pol, force_mid}, 9'h002);
    rd(8'h1D, 8'hBF);
    wr(8'h1D, 8'h7F);
    chk({pol, force_mid}, 9'h001);
    $display("test offset done");
  endtask

  // Power down zeroes currents and releases them again
  task automatic test_power();
    wr(8'h1C, 8'h8F);
    chk(pd, 1'b1);
    chk(gain_cur, 9'h000);
    chk(tot_cur, 9'h000);
    wr(8'h1C, 8'h0F);
    chk(pd, 1'b0);
    chk(tot_cur, 9'h09F);
    $display("test power done");
  endtask

  // Reserved bit and unmapped addresses
  task automatic test_reserved();
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'hBF);
    chk({pd, sink, step, gcode}, 9'h07F);
    wr(8'h1E, 8'h55);
    rd(8'h1E, 8'h00);
    rd(8'h1C, 8'hBF);
    rd(8'h1D, 8'h7F);
    $display("test reserved done");
  endtask

  // Reset in mid-run restores both registers and the currents
  task automatic test_midreset();
    @(negedge clock);
    arst_n = 1'b0;
    @(negedge clock);
    chk(tot_cur, 9'h000);
    @(negedge clock);
    arst_n = 1'b1;
    rd(8'h1C, 8'h30);
    rd(8'h1D, 8'h40);
    chk(gain_cur, 9'h010);
    chk(tot_cur, 9'h080);
    $display("test midreset done");
  endtask

  // Counts and verdict, then end of run
  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    fails = 0;
    checked = 0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    test_reset();
    test_gain();
    test_offset();
    test_power();
    test_reserved();
    test_midreset();
    report_and_stop();
  end

  // Watchdog well beyond the roughly 170 cycles the tests need
  initial begin
    #50000;
    fails++;
    report_and_stop();
  end
endmodule
